// File: rtl/rais_top.sv
// reset cause capture, supply monitor control and interrupt vector selection
// assumes an apb master on pclk, a core that acks the vector shown,
// and async pins and analog levels that are synchronised here
//
// Behaviour
// - flag set when supply below flag-type level
// - flag cleared when disabled or supply recovers
// - enabled flag set raises supply interrupt
// - code 000 disables; 101-111 not allowed
// - codes 001/010 cause power-on reset, no flag
// - codes 011/100 set flag and interrupt
// - watchdog cause set; cleared by por, zero write
// - pin cause set; cleared by por, zero write
// - power-on cause set; cleared by zero write
// - all resets go to vector 0x000
// - pin irq 0x001, pin change 0x002
// - timer 0x003-0x006, comparator 0x007
// - watchdog 0x008, supply 0x009, converter 0x00a
// - pin activity interrupts even as outputs
// - any masked pin change raises request
// - pin change detected without clock
// - level mode requests while pin low
// - edges seen only with clock running
// - low level detected asynchronously for wake
// - level must last through start-up
// - sense: low, any, falling, rising
// - watchdog cause forces reset enable high
// - pin flag held clear in level mode
`include "rais_regs.svh"

module rais_top
	import rais_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int NUM_PINS = 4
) (
	input wire logic pclk, // bus clock, 20 mhz
	input wire logic presetn, // power-on reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [ADDR_W-1:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic ext_irq_pin_zero, // external interrupt pin
	input wire logic [NUM_PINS-1:0] change_watch_pins, // pin change pins
	input wire logic pin_reset_n, // external reset pin, active low
	input wire logic wdt_reset_evt, // watchdog reset pulse
	input wire logic supply_below, // analog: supply under selected level
	input wire logic [6:0] src_req, // timer, comparator, watchdog, converter
	output logic [6:0] src_ack, // ack pulse back to those sources
	input wire logic irq_ack, // core took the shown vector
	output logic irq_valid, // a vector is offered
	output logic [3:0] irq_vector, // vector address offered
	output logic core_reset, // core held at reset vector
	output logic wake_req, // async wake for sleeping clocks
	output logic watchdog_reset_enable, // effective watchdog reset enable
	output logic supply_monitor_flag // supply flag level
);

	initial begin
		if (ADDR_W < 8 || NUM_PINS != 4) begin
			$error("rais_top: unsupported parameters");
		end
	end

	// ************************************
	// decode helpers
	// ************************************
	function automatic logic is_flag_code(input logic [2:0] c);
		is_flag_code = (c == RAIS_LVL_FLAG_LO) || (c == RAIS_LVL_FLAG_HI);
	endfunction

	function automatic logic is_reset_code(input logic [2:0] c);
		is_reset_code = (c == RAIS_LVL_RST_LO) || (c == RAIS_LVL_RST_HI);
	endfunction

	// ************************************
	// synchronisers
	// ************************************
	logic [9:0] sync_m_r;
	logic [9:0] sync_s_r;
	logic [NUM_PINS-1:0] pcw_p_r;
	logic ext_p_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_m_r <= `RAIS_SYNC_RST;
			sync_s_r <= `RAIS_SYNC_RST;
		end else begin
			sync_m_r <= {1'b0, supply_below, pin_reset_n, ext_irq_pin_zero,
				change_watch_pins, 2'b00};
			sync_s_r <= sync_m_r;
		end
	end

	logic sup_s;
	logic rstpin_s;
	logic ext_s;
	logic [NUM_PINS-1:0] pcw_s;
	assign sup_s = sync_s_r[8];
	assign rstpin_s = sync_s_r[7];
	assign ext_s = sync_s_r[6];
	assign pcw_s = sync_s_r[5:2];

	// previous samples, sampled only while the clock runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pcw_p_r <= '0;
			// idle-high pin, so no false edge right after reset
			ext_p_r <= 1'b1;
		end else begin
			pcw_p_r <= pcw_s;
			ext_p_r <= ext_s;
		end
	end

	// ************************************
	// apb decode
	// ************************************
	logic [5:0] idx;
	logic mapped;
	logic wr_en;
	logic rd_setup;
	assign idx = paddr[7:2];
	assign wr_en = psel && penable && pwrite && mapped;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_comb begin
		case (idx)
			`RAIS_IDX_PC_MASK, `RAIS_IDX_PC_FLAG, `RAIS_IDX_PC_EN,
			`RAIS_IDX_EXT_EN, `RAIS_IDX_EXT_FLAG, `RAIS_IDX_EXT_SENSE,
			`RAIS_IDX_WDT_CTRL, `RAIS_IDX_SUPPLY, `RAIS_IDX_RST_CAUSE: begin
				mapped = (paddr[1:0] == 2'b00) && ((paddr >> 8) == '0);
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// ************************************
	// control registers
	// ************************************
	logic [NUM_PINS-1:0] pc_mask_r;
	logic pc_en_r;
	logic ext_en_r;
	logic [1:0] ext_sense_r;
	logic wre_r;
	logic sup_ie_r;
	logic [2:0] sup_level_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_mask_r <= '0;
			pc_en_r <= 1'b0;
			ext_en_r <= 1'b0;
			ext_sense_r <= RAIS_SENSE_LOW;
			wre_r <= 1'b0;
		end else if (wr_en) begin
			case (idx)
				`RAIS_IDX_PC_MASK: pc_mask_r <= pwdata[NUM_PINS-1:0];
				`RAIS_IDX_PC_EN: pc_en_r <= pwdata[0];
				`RAIS_IDX_EXT_EN: ext_en_r <= pwdata[0];
				`RAIS_IDX_EXT_SENSE: ext_sense_r <= pwdata[1:0];
				`RAIS_IDX_WDT_CTRL: wre_r <= pwdata[`RAIS_WRE_BIT];
				default: begin
				end
			endcase
		end
	end

	logic [2:0] sup_code_wr;
	assign sup_code_wr = pwdata[2:0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sup_ie_r <= 1'(`RAIS_SUPPLY_RST >> `RAIS_SUP_IE_BIT);
			sup_level_r <= RAIS_LVL_OFF;
		end else if (wr_en && idx == `RAIS_IDX_SUPPLY) begin
			sup_ie_r <= pwdata[`RAIS_SUP_IE_BIT];
			// forbidden codes leave the level unchanged
			if (sup_code_wr <= RAIS_LVL_FLAG_HI) begin
				sup_level_r <= sup_code_wr;
			end
		end
	end

	logic [2:0] rst_cause_r; // {watchdog, pin, power-on}

	// cause flag wins over a cleared enable bit
	assign watchdog_reset_enable = wre_r | rst_cause_r[2];

	// ************************************
	// supply monitor
	// ************************************
	logic sup_flag_r;
	logic sup_pend_r;
	logic sup_por;

	// the analog side already compares against the selected level
	assign sup_por = is_reset_code(sup_level_r) && sup_s;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sup_flag_r <= 1'b0;
		end else if (is_flag_code(sup_level_r) && sup_s) begin
			sup_flag_r <= 1'b1;
		end else begin
			sup_flag_r <= 1'b0;
		end
	end

	assign supply_monitor_flag = sup_flag_r;

	logic ack_take;
	logic [3:0] ack_idx;
	logic [3:0] irq_vector_r;
	logic irq_valid_r;
	assign ack_take = irq_ack && irq_valid_r;
	assign ack_idx = irq_vector_r - 4'h1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sup_pend_r <= 1'b0;
		end else if (is_flag_code(sup_level_r) && sup_s && !sup_flag_r && sup_ie_r) begin
			sup_pend_r <= 1'b1;
		end else if (ack_take && ack_idx == RAIS_IRQ_SUPPLY) begin
			sup_pend_r <= 1'b0;
		end
	end

	// ************************************
	// reset causes and core reset
	// ************************************
	logic [2:0] cause_keep;
	logic core_reset_r;
	logic core_rst_nxt;
	logic cause_wr;
	assign cause_wr = wr_en && idx == `RAIS_IDX_RST_CAUSE;
	assign cause_keep = cause_wr ?
		{pwdata[`RAIS_WATCHDOG_RESET_CAUSE_BIT], pwdata[`RAIS_PIN_RESET_CAUSE_BIT], pwdata[`RAIS_POWERON_RESET_CAUSE_BIT]} : 3'b111;

	// presetn is the power-on reset itself
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_cause_r <= `RAIS_RST_CAUSE_POR;
		end else if (sup_por) begin
			rst_cause_r <= `RAIS_RST_CAUSE_POR;
		end else begin
			// a new cause wins over a zero written in the same cycle
			rst_cause_r[2] <= (rst_cause_r[2] & cause_keep[2]) | wdt_reset_evt;
			rst_cause_r[1] <= (rst_cause_r[1] & cause_keep[1]) | !rstpin_s;
			rst_cause_r[0] <= rst_cause_r[0] & cause_keep[0];
		end
	end

	assign core_rst_nxt = sup_por || !rstpin_s || wdt_reset_evt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_reset_r <= 1'b1;
		end else begin
			core_reset_r <= core_rst_nxt;
		end
	end

	assign core_reset = core_reset_r;

	// ************************************
	// external pin and pin change
	// ************************************
	logic ext_level;
	logic ext_edge;
	logic ext_flag_r;
	logic pc_flag_r;
	logic pc_hit;

	// pins are read whatever their direction, so software can provoke them
	assign ext_level = (ext_sense_r == RAIS_SENSE_LOW);

	always_comb begin
		case (ext_sense_r)
			RAIS_SENSE_ANY: ext_edge = ext_s ^ ext_p_r;
			RAIS_SENSE_FALL: ext_edge = ext_p_r && !ext_s;
			RAIS_SENSE_RISE: ext_edge = !ext_p_r && ext_s;
			default: ext_edge = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_flag_r <= 1'b0;
		end else if (ext_level) begin
			ext_flag_r <= 1'b0;
		end else if (ext_edge) begin
			ext_flag_r <= 1'b1;
		end else if ((wr_en && idx == `RAIS_IDX_EXT_FLAG && pwdata[0])
			|| (ack_take && ack_idx == RAIS_IRQ_EXT)) begin
			ext_flag_r <= 1'b0;
		end
	end

	assign pc_hit = |((pcw_s ^ pcw_p_r) & pc_mask_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_flag_r <= 1'b0;
		end else if (pc_hit) begin
			pc_flag_r <= 1'b1;
		end else if ((wr_en && idx == `RAIS_IDX_PC_FLAG && pwdata[0])
			|| (ack_take && ack_idx == RAIS_IRQ_PC)) begin
			pc_flag_r <= 1'b0;
		end
	end

	// raw pins against the last synced sample; needs no running clock
	logic pc_wake;
	logic ext_wake;
	assign pc_wake = pc_en_r && |((change_watch_pins ^ pcw_s) & pc_mask_r);
	assign ext_wake = ext_en_r && ext_level && !ext_irq_pin_zero;
	// wake only: the vector needs the synced level still low later
	assign wake_req = pc_wake || ext_wake || irq_valid_r;

	// ************************************
	// vector selection
	// ************************************
	logic [`RAIS_NUM_IRQ-1:0] req;
	logic [`RAIS_NUM_IRQ-1:0] req_live;
	logic any;
	logic [3:0] win;

	// level mode requests straight from the pin, no latch
	assign req[0] = ext_en_r && (ext_level ? !ext_s : ext_flag_r);
	assign req[1] = pc_en_r && pc_flag_r;
	assign req[7:2] = src_req[5:0];
	assign req[8] = sup_pend_r;
	assign req[9] = src_req[6];

	// drop the source being acked so it is not offered twice
	always_comb begin
		req_live = req;
		if (ack_take) begin
			req_live[ack_idx] = 1'b0;
		end
	end

	rais_prio #(
		.N(`RAIS_NUM_IRQ),
		.IW(4)
	) u_prio (
		.req(req_live),
		.any(any),
		.idx(win)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_valid_r <= 1'b0;
			irq_vector_r <= `RAIS_VEC_RESET;
		end else if (core_rst_nxt) begin
			// next value, so no vector stands beside a freshly raised core reset
			irq_valid_r <= 1'b0;
			irq_vector_r <= `RAIS_VEC_RESET;
		end else begin
			irq_valid_r <= any;
			irq_vector_r <= any ? win + `RAIS_VEC_EXT : `RAIS_VEC_RESET;
		end
	end

	assign irq_valid = irq_valid_r;
	assign irq_vector = irq_vector_r;

	// ack pulses to the outside sources, vectors 0x003 to 0x008 and 0x00a
	genvar g;
	generate
		for (g = 0; g < 7; g++) begin : g_ack
			localparam logic [3:0] SRC_IDX = (g < 6) ? 4'(g + 2) : 4'h9;
			assign src_ack[g] = ack_take && (ack_idx == SRC_IDX);
		end
	endgenerate

	// ************************************
	// read data
	// ************************************
	logic [31:0] rd_val;

	always_comb begin
		rd_val = 32'h0000_0000;
		case (idx)
			`RAIS_IDX_PC_MASK: rd_val[NUM_PINS-1:0] = pc_mask_r;
			`RAIS_IDX_PC_FLAG: rd_val[0] = pc_flag_r;
			`RAIS_IDX_PC_EN: rd_val[0] = pc_en_r;
			`RAIS_IDX_EXT_EN: rd_val[0] = ext_en_r;
			`RAIS_IDX_EXT_FLAG: rd_val[0] = ext_flag_r;
			`RAIS_IDX_EXT_SENSE: rd_val[1:0] = ext_sense_r;
			`RAIS_IDX_WDT_CTRL: rd_val[`RAIS_WRE_BIT] = watchdog_reset_enable;
			`RAIS_IDX_SUPPLY: begin
				rd_val[`RAIS_SUP_FLAG_BIT] = sup_flag_r;
				rd_val[`RAIS_SUP_IE_BIT] = sup_ie_r;
				rd_val[2:0] = sup_level_r;
			end
			`RAIS_IDX_RST_CAUSE: begin
				rd_val[`RAIS_WATCHDOG_RESET_CAUSE_BIT] = rst_cause_r[2];
				rd_val[`RAIS_PIN_RESET_CAUSE_BIT] = rst_cause_r[1];
				rd_val[`RAIS_POWERON_RESET_CAUSE_BIT] = rst_cause_r[0];
			end
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// captured in the setup cycle so the access phase needs no wait
	logic [31:0] prdata_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_r <= mapped ? rd_val : 32'h0000_0000;
		end
	end

	assign prdata = prdata_r;

endmodule

// File: common/rais_regs.svh
// register offsets, field positions, reset values and vector addresses
// assumes 32-bit apb words, byte address = four times the register index
`ifndef RAIS_REGS_SVH
`define RAIS_REGS_SVH

// ************************************
// register indices (byte address = 4 * index)
// ************************************
`define RAIS_IDX_PC_MASK 6'h10
`define RAIS_IDX_PC_FLAG 6'h11
`define RAIS_IDX_PC_EN 6'h12
`define RAIS_IDX_EXT_EN 6'h13
`define RAIS_IDX_EXT_FLAG 6'h14
`define RAIS_IDX_EXT_SENSE 6'h15
`define RAIS_IDX_WDT_CTRL 6'h31
`define RAIS_IDX_SUPPLY 6'h34
`define RAIS_IDX_RST_CAUSE 6'h3b

// ************************************
// field positions
// ************************************
`define RAIS_SUP_FLAG_BIT 7
`define RAIS_SUP_IE_BIT 6
`define RAIS_WATCHDOG_RESET_CAUSE_BIT 3
`define RAIS_PIN_RESET_CAUSE_BIT 1
`define RAIS_POWERON_RESET_CAUSE_BIT 0
`define RAIS_WRE_BIT 3

// ************************************
// reset values
// ************************************
`define RAIS_SUPPLY_RST 8'h00
`define RAIS_RST_CAUSE_POR 3'h1
`define RAIS_SYNC_RST 10'h0c0

// ************************************
// vector addresses
// ************************************
`define RAIS_VEC_RESET 4'h0
`define RAIS_VEC_EXT 4'h1
`define RAIS_VEC_PC 4'h2
`define RAIS_VEC_FIRST_SRC 4'h3
`define RAIS_VEC_SUPPLY 4'h9
`define RAIS_NUM_IRQ 10

`endif

// File: common/rais_pkg.sv
// types shared by the reset and interrupt source block
// assumes nothing beyond the register header
package rais_pkg;

	typedef enum logic [1:0] {
		RAIS_SENSE_LOW = 2'b00,
		RAIS_SENSE_ANY = 2'b01,
		RAIS_SENSE_FALL = 2'b10,
		RAIS_SENSE_RISE = 2'b11
	} rais_sense_t;

	typedef enum logic [2:0] {
		RAIS_LVL_OFF = 3'b000,
		RAIS_LVL_RST_LO = 3'b001,
		RAIS_LVL_RST_HI = 3'b010,
		RAIS_LVL_FLAG_LO = 3'b011,
		RAIS_LVL_FLAG_HI = 3'b100
	} rais_level_t;

	// interrupt index i is served at vector address i + 1
	typedef enum logic [3:0] {
		RAIS_IRQ_EXT = 4'h0,
		RAIS_IRQ_PC = 4'h1,
		RAIS_IRQ_SUPPLY = 4'h8
	} rais_irq_t;

endpackage

// File: rtl/rais_prio.sv
// fixed priority picker: lowest index wins
// assumes requests are levels on the same clock as the user
module rais_prio #(
	parameter int N = 10,
	parameter int IW = 4
) (
	input wire logic [N-1:0] req, // pending requests
	output logic any, // at least one pending
	output logic [IW-1:0] idx // index of the winner
);

	initial begin
		if (N < 1 || N > (1 << IW)) begin
			$error("rais_prio: N does not fit IW");
		end
	end

	always_comb begin
		any = 1'b0;
		idx = '0;
		// walk downward so the lowest set index is written last
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				any = 1'b1;
				idx = IW'(i);
			end
		end
	end

endmodule

// File: test/rais_checker.sv
// concurrent checks on the reset and interrupt source block ports
// assumes one clock domain, pclk, with presetn as async active-low reset
module rais_checker (
	input wire logic pclk, // bus clock
	input wire logic presetn, // reset, active low
	input wire logic psel, // apb select
	input wire logic pwrite, // apb direction
	input wire logic pin_reset_n, // reset pin
	input wire logic wdt_reset_evt, // watchdog reset pulse
	input wire logic supply_below, // supply under level
	input wire logic [6:0] src_req, // source requests
	input wire logic [6:0] src_ack, // source acks
	input wire logic irq_ack, // core take
	input wire logic irq_valid, // vector offered
	input wire logic [3:0] irq_vector, // offered vector
	input wire logic core_reset, // core held
	input wire logic wake_req, // wake request
	input wire logic watchdog_reset_enable, // effective enable
	input wire logic supply_monitor_flag // supply flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ****
	// properties
	// ****
	AST_RST_NO_VEC: assert property (core_reset |-> !irq_valid && irq_vector == 4'h0)
		else $error("vector offered while core held");
	AST_WDT_CAUSE: assert property (wdt_reset_evt |=> watchdog_reset_enable)
		else $error("watchdog cause did not force enable");
	AST_WDT_CORE: assert property (wdt_reset_evt |-> ##[1:2] core_reset)
		else $error("watchdog reset did not reach core");
	// a supply reset may clear the cause; the level reaches it two edges late
	AST_WRE_HOLD: assert property (watchdog_reset_enable && !(psel && pwrite)
		&& !$past(supply_below, 2)
		|=> watchdog_reset_enable)
		else $error("reset enable dropped without a write");
	AST_VEC_RANGE: assert property (irq_valid |-> irq_vector inside {[4'h1:4'ha]})
		else $error("vector outside table");
	AST_SRC_ACK: assert property (irq_ack && irq_valid && irq_vector > 4'h2 && irq_vector != 4'h9
		|-> src_ack == ((irq_vector == 4'ha) ? 7'h40 : 7'(7'h1 << (irq_vector - 4'h3))))
		else $error("wrong source acknowledged");
	AST_PRIO: assert property ($past(src_req[0]) && !core_reset && !$past(core_reset)
		&& !$past(irq_ack) |-> irq_valid && irq_vector <= 4'h3)
		else $error("lower vector not served first");
	AST_SUP_CLR: assert property (!supply_below [*5] |-> !supply_monitor_flag)
		else $error("supply flag kept after recovery");
	AST_PIN_RST: assert property (!pin_reset_n [*5] |-> core_reset)
		else $error("pin reset not applied");
	AST_WAKE: assert property (irq_valid |-> wake_req)
		else $error("request without wake");
endmodule

bind rais_top rais_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .pwrite(pwrite),
	.pin_reset_n(pin_reset_n), .wdt_reset_evt(wdt_reset_evt), .supply_below(supply_below),
	.src_req(src_req), .src_ack(src_ack), .irq_ack(irq_ack), .irq_valid(irq_valid),
	.irq_vector(irq_vector), .core_reset(core_reset), .wake_req(wake_req),
	.watchdog_reset_enable(watchdog_reset_enable), .supply_monitor_flag(supply_monitor_flag));

// File: test/rais_core_model.sv
// behavioural core: takes offered vectors after a set stall, logs them
// assumes irq_valid and irq_vector are registered on pclk
module rais_core_model (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic en, // accept vectors
	input wire logic [3:0] stall, // wait before take
	input wire logic irq_valid, // vector offered
	input wire logic [3:0] irq_vector, // offered vector
	input wire logic core_reset, // core held
	output logic irq_ack // take pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] log[$];
	int wait_cnt;

	// one-cycle take; a vector that changes meanwhile is taken as shown
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ack <= 1'b0;
			wait_cnt <= 0;
		end else if (irq_ack) begin
			irq_ack <= 1'b0;
			wait_cnt <= 0;
			if (irq_valid === 1'b1)
				log.push_back(irq_vector);
		end else if (en && irq_valid === 1'b1 && !core_reset) begin
			if (wait_cnt >= stall)
				irq_ack <= 1'b1;
			else
				wait_cnt <= wait_cnt + 1;
		end
	end
endmodule

// File: test/rais_top_tb.sv
// self-checking bench for the reset and interrupt source block
// assumes the core model file and the bound checker are compiled first
`include "rais_regs.svh"

module rais_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] MASK = {`RAIS_IDX_PC_MASK, 2'b00};
	localparam logic [7:0] PCEN = {`RAIS_IDX_PC_EN, 2'b00};
	localparam logic [7:0] EXTEN = {`RAIS_IDX_EXT_EN, 2'b00};
	localparam logic [7:0] EXTF = {`RAIS_IDX_EXT_FLAG, 2'b00};
	localparam logic [7:0] SENSE = {`RAIS_IDX_EXT_SENSE, 2'b00};
	localparam logic [7:0] WDT = {`RAIS_IDX_WDT_CTRL, 2'b00};
	localparam logic [7:0] SUP = {`RAIS_IDX_SUPPLY, 2'b00};
	localparam logic [7:0] RC = {`RAIS_IDX_RST_CAUSE, 2'b00};
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} rais_row_t;
	rais_row_t rows[11] = '{
		'{RC, 32'h0b, 32'h01, 1'b0}, // ones keep every cause; only power-on is set
		'{RC, 32'h00, 32'h00, 1'b0},
		'{SUP, 32'hff, 32'h40, 1'b0}, // level kept, flag ignored
		'{SUP, 32'h43, 32'h43, 1'b0}, '{SUP, 32'h05, 32'h03, 1'b0}, '{SUP, 32'h00, 32'h00, 1'b0},
		'{MASK, 32'hff, 32'h0f, 1'b0},
		'{WDT, 32'h08, 32'h08, 1'b0}, '{WDT, 32'h00, 32'h00, 1'b0},
		'{8'h80, 32'h55, 32'h00, 1'b1}, '{8'hd1, 32'h55, 32'h00, 1'b1}};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd_data;
	logic ext_pin, pin_rst_n, wdt_evt, sup_below, core_en, irq_ack, irq_valid;
	logic core_reset, wake_req, wre, sup_flag;
	logic [3:0] pins, irq_vector, stall;
	logic [6:0] src_req, src_ack, src_raise;
	int failures, checks, n0;

	rais_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_irq_pin_zero(ext_pin), .change_watch_pins(pins),
		.pin_reset_n(pin_rst_n), .wdt_reset_evt(wdt_evt), .supply_below(sup_below),
		.src_req(src_req), .src_ack(src_ack), .irq_ack(irq_ack), .irq_valid(irq_valid),
		.irq_vector(irq_vector), .core_reset(core_reset), .wake_req(wake_req),
		.watchdog_reset_enable(wre), .supply_monitor_flag(sup_flag));
	rais_core_model core (.pclk(pclk), .presetn(presetn), .en(core_en), .stall(stall),
		.irq_valid(irq_valid), .irq_vector(irq_vector), .core_reset(core_reset),
		.irq_ack(irq_ack));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// sources drop their request on the ack, as the timer and others do
	always @(posedge pclk) src_req <= presetn ? ((src_req & ~src_ack) | src_raise) : 7'h00;

	// ****
	// tasks
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic timeout();
		failures++;
		tally_and_finish();
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// one transfer, then an idle cycle so the next call never reassigns in the same step
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16)
			timeout();
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_log(input int n);
		int k;
		k = 0;
		while (core.log.size() < n && k < 300) begin
			@(posedge pclk);
			k++;
		end
		if (k >= 300)
			timeout();
	endtask

	// ****
	// sequence
	// ****
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{wdt_evt, sup_below, src_raise, pins, stall} = '0;
		{ext_pin, pin_rst_n, core_en} = 3'b111;
		failures = 0;
		checks = 0;
		tick(6);
		presetn <= 1'b1;
		tick(1);
		foreach (rows[i]) begin
			apb(rows[i].a, 1'b1, rows[i].d);
			chk(rd_err, rows[i].e);
			apb(rows[i].a, 1'b0, 32'h0);
			chk(rd_data, rows[i].q);
		end
		for (int l = 1; l <= 4; l++) begin
			apb(SUP, 1'b1, 32'h40 | l);
			apb(RC, 1'b1, 32'h0);
			n0 = core.log.size();
			sup_below <= 1'b1;
			tick(6);
			chk(sup_flag, l >= 3);
			chk(core_reset, l <= 2);
			sup_below <= 1'b0;
			tick(8);
			chk(sup_flag, 0);
			chk(core.log.size() - n0, l >= 3);
			if (l >= 3)
				chk(core.log[$], `RAIS_VEC_SUPPLY);
			apb(RC, 1'b0, 32'h0);
			chk(rd_data, l <= 2);
		end
		apb(SUP, 1'b1, 32'h03);
		sup_below <= 1'b1;
		tick(6);
		chk(sup_flag, 1);
		apb(SUP, 1'b1, 32'h00);
		tick(2);
		chk(sup_flag, 0);
		sup_below <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			apb(SENSE, 1'b1, m);
			apb(EXTF, 1'b1, 32'h1);
			ext_pin <= 1'b0;
			tick(6);
			apb(EXTF, 1'b0, 32'h0);
			chk(rd_data, m == 1 || m == 2);
			apb(EXTF, 1'b1, 32'h1);
			ext_pin <= 1'b1;
			tick(6);
			apb(EXTF, 1'b0, 32'h0);
			chk(rd_data, m == 1 || m == 3);
		end
		apb(SENSE, 1'b1, 32'h0);
		apb(EXTEN, 1'b1, 32'h1);
		n0 = core.log.size();
		ext_pin <= 1'b0;
		#1 chk(wake_req, 1);
		wait_log(n0 + 2);
		chk(core.log[$], `RAIS_VEC_EXT);
		ext_pin <= 1'b1; // low held until two requests were taken
		tick(6);
		n0 = core.log.size();
		tick(10);
		chk(core.log.size(), n0);
		apb(RC, 1'b1, 32'h0);
		wdt_evt <= 1'b1;
		tick(1);
		wdt_evt <= 1'b0;
		tick(4);
		apb(RC, 1'b0, 32'h0);
		chk(rd_data, 32'h08);
		apb(WDT, 1'b1, 32'h0);
		chk(wre, 1);
		apb(RC, 1'b1, 32'h0);
		chk(wre, 0);
		pin_rst_n <= 1'b0;
		tick(5);
		chk(core_reset, 1);
		pin_rst_n <= 1'b1;
		n0 = 0;
		while (core_reset !== 1'b0 && n0 < 20) begin
			tick(1);
			n0++;
		end
		if (n0 >= 20)
			timeout();
		apb(RC, 1'b0, 32'h0);
		chk(rd_data, 32'h02);
		// hold every source pending, then let a slow core drain them
		core_en <= 1'b0;
		stall <= 4'h3;
		apb(MASK, 1'b1, 32'h1);
		apb(PCEN, 1'b1, 32'h1);
		apb(SENSE, 1'b1, 32'h2);
		apb(SUP, 1'b1, 32'h43);
		pins <= 4'h1; // only the pin level matters, not its direction
		#1 chk(wake_req, 1);
		tick(1);
		ext_pin <= 1'b0;
		src_raise <= 7'h7f;
		sup_below <= 1'b1;
		tick(1);
		src_raise <= 7'h00;
		tick(8);
		chk(irq_vector, `RAIS_VEC_EXT);
		n0 = core.log.size();
		core_en <= 1'b1;
		wait_log(n0 + 10);
		for (int k = 0; k < 10; k++)
			chk(core.log[n0 + k], k + 1);
		sup_below <= 1'b0;
		ext_pin <= 1'b1;
		tick(10);
		presetn <= 1'b0;
		tick(2);
		presetn <= 1'b1;
		tick(1);
		apb(RC, 1'b0, 32'h0);
		chk(rd_data, 32'h01);
		apb(SUP, 1'b0, 32'h0);
		chk(rd_data, 32'h00);
		tally_and_finish();
	end
endmodule
